// >>> verilog/cpf_cfg.svh
// Purpose: offsets, field positions and reset values of the follower control registers
// Assumes: registers sit in aligned 32-bit words
// Notes:   definitions only
`ifndef CPF_CFG_SVH
`define CPF_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CPF_OFS_CTRL       8'h00
`define CPF_OFS_STATUS     8'h04
`define CPF_OFS_DATA       8'h08
`define CPF_OFS_COUNT      8'h0c

// ----------------------------------------------------------------
// control field positions and reset value
// ----------------------------------------------------------------
`define CPF_CTRL_EN_BIT    0
`define CPF_CTRL_USER_BIT  1
`define CPF_CTRL_CPNUM_LSB 4
`define CPF_CTRL_WAIT_LSB  8
`define CPF_CTRL_WORDS_LSB 12
`define CPF_CTRL_RESET     32'h0000_0000

`endif

// >>> verilog/cpf_pkg.sv
// Purpose: types shared by the coprocessor pipeline follower files
// Assumes: nothing
// Notes:   handshake codes are the documented two-bit encodings
`default_nettype none

package cpf_pkg;

  typedef enum logic [1:0] {
    cpf_hs_wait   = 2'h0,
    cpf_hs_go     = 2'h1,
    cpf_hs_absent = 2'h2,
    cpf_hs_last   = 2'h3
  } cpf_hs_t;

  typedef enum logic [3:0] {
    cpf_st_idle = 4'h1,
    cpf_st_wait = 4'h2,
    cpf_st_xfer = 4'h4,
    cpf_st_mem  = 4'h8
  } cpf_state_t;

  typedef enum logic [1:0] {
    cpf_cl_none   = 2'h0,
    cpf_cl_ldst   = 2'h1,
    cpf_cl_move   = 2'h2,
    cpf_cl_dataop = 2'h3
  } cpf_cls_t;

endpackage : cpf_pkg

`default_nettype wire

// >>> verilog/cpf_decode.sv
// Purpose: classify an instruction and decide whether this follower claims it
// Assumes: 32-bit instruction encoding, coprocessor number in bits 11:8
// Notes:   purely combinational
`default_nettype none

module cpf_decode
  import cpf_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic [3:0]  cp_num,
  input  wire logic        enable,
  input  wire logic        user_ok,
  input  wire logic        privilege_flag_n,
  input  wire logic        compact_isa_flag,
  output var  logic        ours,
  output var  cpf_cls_t    cls,
  output var  logic        load
);

  always_comb begin
    cls  = cpf_cl_none;
    load = instr[20];
    if (instr[27:25] == 3'h6) begin
      cls = cpf_cl_ldst;
    end else if (instr[27:24] == 4'he) begin
      cls = instr[4] ? cpf_cl_move : cpf_cl_dataop;
    end
    // compact instruction set carries no coprocessor instructions
    ours = enable && !compact_isa_flag && (cls != cpf_cl_none) &&
           (instr[11:8] == cp_num) && (privilege_flag_n || user_ok);
  end

endmodule : cpf_decode

`default_nettype wire

// >>> verilog/cpf_ahb_regs.sv
// Purpose: AHB-Lite slave for the follower control and status words
// Assumes: single word transfers, one wait state on every access
// Notes:   unmapped reads return zero, response is always OKAY
`default_nettype none
`include "cpf_cfg.svh"

module cpf_ahb_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] status_in,
  input  wire logic [31:0] data_in,
  input  wire logic [31:0] count_in,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [31:0]      ctrl
);

  logic        pend_reg,  pend_next;
  logic        wr_reg,    wr_next;
  logic [7:0]  addr_reg,  addr_next;
  logic [31:0] ctrl_next, rdata_next;

  // ----------------------------------------------------------------
  // address phase capture, data phase answer one cycle later
  // ----------------------------------------------------------------
  always_comb begin
    pend_next  = 1'b0;
    wr_next    = wr_reg;
    addr_next  = addr_reg;
    ctrl_next  = ctrl;
    rdata_next = hrdata;
    if (hsel && htrans[1] && hready && (hsize == 3'h2)) begin
      pend_next = 1'b1;
      wr_next   = hwrite;
      addr_next = haddr[7:0];
    end
    if (pend_reg) begin
      if (wr_reg && addr_reg == `CPF_OFS_CTRL) begin
        ctrl_next = hwdata;
      end
      unique case (addr_reg)
        `CPF_OFS_CTRL:   rdata_next = ctrl;
        `CPF_OFS_STATUS: rdata_next = status_in;
        `CPF_OFS_DATA:   rdata_next = data_in;
        `CPF_OFS_COUNT:  rdata_next = count_in;
        default:         rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg  <= 1'b0;
      wr_reg    <= 1'b0;
      addr_reg  <= 8'h0;
      ctrl      <= `CPF_CTRL_RESET;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      pend_reg  <= pend_next;
      wr_reg    <= wr_next;
      addr_reg  <= addr_next;
      ctrl      <= ctrl_next;
      hrdata    <= rdata_next;
      hreadyout <= !pend_next;
      hresp     <= 1'b0;
    end
  end

endmodule : cpf_ahb_regs

`default_nettype wire

// >>> verilog/cpf_follower.sv
// Purpose: coprocessor pipeline follower attached to a core's coprocessor port
// Assumes: all port inputs synchronous to hclk, core outputs come from registers
// Notes:   configured and observed over AHB-Lite; one claimed coprocessor number
`default_nettype none
`include "cpf_cfg.svh"

// Contract
// - burst length n means n+1 words, zero one word, all ones sixteen
// - burst length stays zero when the follower is not active
// - follower advances only on edges with the follower clock enable high
// - instruction enters the follower when entry strobe low and enable high
// - 32-bit data in from the core, 32-bit registered data back
// - late cancel in first memory cycle drops instruction with no state change
// - handshake codes: 10 absent, 00 wait, 01 go, 11 last
// - follower receives each instruction one cycle behind the core
// - no new instruction enters Execute while the enable is low
// - commit only when execute pass high with go or last
// - go means more execute cycles follow; commit also needs execute pass
// - transfers answer go while two or more words remain, last at one
// - single item: waits then last; data operations answer last
// - without a claimable coprocessor both handshakes read absent
// - idle outputs are merge-neutral: absent code, zero data, zero burst
module cpf_follower
  import cpf_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        follower_clock_enable,
  input  wire logic [31:0] follower_instruction_bus,
  input  wire logic        instr_entry_n,
  input  wire logic        execute_pass,
  input  wire logic        late_cancel,
  input  wire logic        compact_isa_flag,
  input  wire logic        privilege_flag_n,
  input  wire logic [31:0] data_to_follower,
  output logic [1:0]       decode_handshake,
  output logic [1:0]       execute_handshake,
  output logic [31:0]      data_from_follower,
  output logic [3:0]       burst_word_count
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic        enable;
  logic        user_ok;
  logic [3:0]  cp_num;
  logic [3:0]  wait_cfg;
  logic [3:0]  words_cfg;
  logic        adv;

  logic [31:0] fetch_instr_reg, fetch_instr_next;
  logic        fetch_valid_reg, fetch_valid_next;
  logic [31:0] dec_instr_reg,   dec_instr_next;
  logic        dec_valid_reg,   dec_valid_next;

  cpf_state_t  state_reg,  state_next;
  cpf_cls_t    ex_cls_reg, ex_cls_next;
  logic        ex_load_reg, ex_load_next;
  logic [3:0]  wait_cnt_reg, wait_cnt_next;
  logic [4:0]  remain_reg,   remain_next;
  logic [31:0] data_reg,     data_next;
  logic [15:0] commit_cnt_reg, commit_cnt_next;

  cpf_hs_t     dec_hs_reg, dec_hs_next;
  cpf_hs_t     ex_hs_reg,  ex_hs_next;
  logic [3:0]  burst_reg,  burst_next;
  logic [31:0] dout_reg,   dout_next;

  logic        nd_ours, cd_ours;
  cpf_cls_t    nd_cls,  cd_cls;
  logic        nd_load, cd_load;
  logic        drive_out;

  assign enable    = ctrl[`CPF_CTRL_EN_BIT];
  assign user_ok   = ctrl[`CPF_CTRL_USER_BIT];
  assign cp_num    = ctrl[`CPF_CTRL_CPNUM_LSB +: 4];
  assign wait_cfg  = ctrl[`CPF_CTRL_WAIT_LSB +: 4];
  assign words_cfg = ctrl[`CPF_CTRL_WORDS_LSB +: 4];
  assign adv       = follower_clock_enable && !instr_entry_n;

  // ----------------------------------------------------------------
  // register slave and instruction classifiers
  // ----------------------------------------------------------------
  cpf_ahb_regs u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .status_in ({28'h0, state_reg}),
    .data_in   (data_reg),
    .count_in  ({16'h0, commit_cnt_reg}),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .ctrl      (ctrl)
  );

  cpf_decode u_dec_next (
    .instr            (dec_instr_next),
    .cp_num           (cp_num),
    .enable           (enable),
    .user_ok          (user_ok),
    .privilege_flag_n (privilege_flag_n),
    .compact_isa_flag (compact_isa_flag),
    .ours             (nd_ours),
    .cls              (nd_cls),
    .load             (nd_load)
  );

  cpf_decode u_dec_cur (
    .instr            (dec_instr_reg),
    .cp_num           (cp_num),
    .enable           (enable),
    .user_ok          (user_ok),
    .privilege_flag_n (privilege_flag_n),
    .compact_isa_flag (compact_isa_flag),
    .ours             (cd_ours),
    .cls              (cd_cls),
    .load             (cd_load)
  );

  // ----------------------------------------------------------------
  // fetch and decode stages of the follower
  // ----------------------------------------------------------------
  always_comb begin
    fetch_instr_next = fetch_instr_reg;
    fetch_valid_next = fetch_valid_reg;
    dec_instr_next   = dec_instr_reg;
    dec_valid_next   = dec_valid_reg;
    if (adv) begin
      fetch_instr_next = follower_instruction_bus;
      fetch_valid_next = 1'b1;
      dec_instr_next   = fetch_instr_reg;
      dec_valid_next   = fetch_valid_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_instr_reg <= 32'h0;
      fetch_valid_reg <= 1'b0;
      dec_instr_reg   <= 32'h0;
      dec_valid_reg   <= 1'b0;
    end else begin
      fetch_instr_reg <= fetch_instr_next;
      fetch_valid_reg <= fetch_valid_next;
      dec_instr_reg   <= dec_instr_next;
      dec_valid_reg   <= dec_valid_next;
    end
  end

  // ----------------------------------------------------------------
  // execute and memory stages
  // ----------------------------------------------------------------
  always_comb begin
    state_next      = state_reg;
    ex_cls_next     = ex_cls_reg;
    ex_load_next    = ex_load_reg;
    wait_cnt_next   = wait_cnt_reg;
    remain_next     = remain_reg;
    data_next       = data_reg;
    commit_cnt_next = commit_cnt_reg;
    if (follower_clock_enable) begin
      unique case (state_reg)
        cpf_st_wait: begin
          if (!execute_pass) begin
            state_next = cpf_st_idle;
          end else if (wait_cnt_reg == 4'h1) begin
            state_next = cpf_st_xfer;
          end else begin
            wait_cnt_next = wait_cnt_reg - 4'h1;
          end
        end
        cpf_st_xfer: begin
          if (!execute_pass) begin
            state_next = cpf_st_idle;
          end else if (remain_reg == 5'h1) begin
            state_next = cpf_st_mem;
          end else begin
            remain_next = remain_reg - 5'h1;
          end
        end
        cpf_st_mem: begin
          state_next = cpf_st_idle;
          if (!late_cancel) begin
            commit_cnt_next = commit_cnt_reg + 16'h1;
            if ((ex_cls_reg == cpf_cl_move && !ex_load_reg) ||
                (ex_cls_reg == cpf_cl_ldst && ex_load_reg)) begin
              data_next = data_to_follower;
            end
          end
        end
        default: begin
          state_next = cpf_st_idle;
        end
      endcase
      if (adv && dec_valid_reg && cd_ours &&
          (state_reg == cpf_st_idle || state_reg == cpf_st_mem)) begin
        ex_cls_next   = cd_cls;
        ex_load_next  = cd_load;
        wait_cnt_next = wait_cfg;
        remain_next   = (cd_cls == cpf_cl_ldst) ? {1'b0, words_cfg} + 5'h1 : 5'h1;
        state_next    = (wait_cfg != 4'h0) ? cpf_st_wait : cpf_st_xfer;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= cpf_st_idle;
      ex_cls_reg     <= cpf_cl_none;
      ex_load_reg    <= 1'b0;
      wait_cnt_reg   <= 4'h0;
      remain_reg     <= 5'h0;
      data_reg       <= 32'h0;
      commit_cnt_reg <= 16'h0;
    end else begin
      state_reg      <= state_next;
      ex_cls_reg     <= ex_cls_next;
      ex_load_reg    <= ex_load_next;
      wait_cnt_reg   <= wait_cnt_next;
      remain_reg     <= remain_next;
      data_reg       <= data_next;
      commit_cnt_reg <= commit_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // handshake, burst and data outputs
  // ----------------------------------------------------------------
  always_comb begin
    drive_out = (ex_cls_next == cpf_cl_move) ? ex_load_next :
                (ex_cls_next == cpf_cl_ldst) ? !ex_load_next : 1'b0;
    dec_hs_next = cpf_hs_absent;
    if (dec_valid_next && nd_ours) begin
      if (state_next == cpf_st_wait || state_next == cpf_st_xfer || wait_cfg != 4'h0) begin
        dec_hs_next = cpf_hs_wait;
      end else if (nd_cls == cpf_cl_ldst && words_cfg != 4'h0) begin
        dec_hs_next = cpf_hs_go;
      end else begin
        dec_hs_next = cpf_hs_last;
      end
    end
    ex_hs_next = cpf_hs_absent;
    if (enable && state_next == cpf_st_wait) begin
      ex_hs_next = cpf_hs_wait;
    end else if (enable && state_next == cpf_st_xfer) begin
      ex_hs_next = (remain_next >= 5'h2) ? cpf_hs_go : cpf_hs_last;
    end
    burst_next = 4'h0;
    if (state_next == cpf_st_xfer && ex_cls_next == cpf_cl_ldst) begin
      burst_next = words_cfg;
    end
    dout_next = 32'h0;
    if ((state_next == cpf_st_xfer || state_next == cpf_st_mem) && drive_out) begin
      dout_next = data_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_hs_reg <= cpf_hs_absent;
      ex_hs_reg  <= cpf_hs_absent;
      burst_reg  <= 4'h0;
      dout_reg   <= 32'h0;
    end else begin
      dec_hs_reg <= dec_hs_next;
      ex_hs_reg  <= ex_hs_next;
      burst_reg  <= burst_next;
      dout_reg   <= dout_next;
    end
  end

  assign decode_handshake   = dec_hs_reg;
  assign execute_handshake  = ex_hs_reg;
  assign burst_word_count   = burst_reg;
  assign data_from_follower = dout_reg;

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_hold_stalled;
    !follower_clock_enable |=> $stable(state_reg) && $stable(dec_instr_reg);
  endproperty
  a_hold_stalled: assert property (p_hold_stalled)
    else $error("follower moved while enable low");

  property p_entry_taken;
    adv |=> fetch_instr_reg == $past(follower_instruction_bus);
  endproperty
  a_entry_taken: assert property (p_entry_taken)
    else $error("instruction not taken on entry strobe");

  property p_one_behind;
    adv ##1 adv |=> dec_instr_reg == $past(follower_instruction_bus, 2);
  endproperty
  a_one_behind: assert property (p_one_behind)
    else $error("decode stage not one entry behind fetch");

  property p_burst_len;
    burst_word_count != 4'h0 |-> state_reg == cpf_st_xfer && burst_word_count == words_cfg;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length outside a transfer or wrong");

  property p_off_absent;
    !enable |=> decode_handshake == cpf_hs_absent && execute_handshake == cpf_hs_absent;
  endproperty
  a_off_absent: assert property (p_off_absent)
    else $error("handshake not absent while disabled");

  property p_go_words;
    execute_handshake == cpf_hs_go |-> state_reg == cpf_st_xfer && remain_reg >= 5'h2;
  endproperty
  a_go_words: assert property (p_go_words)
    else $error("go given with fewer than two words left");

  property p_wait_code;
    execute_handshake == cpf_hs_wait |-> state_reg == cpf_st_wait;
  endproperty
  a_wait_code: assert property (p_wait_code)
    else $error("wait code outside busy-wait");

  // only the edge that enters mem is checked: a stalled mem cycle repeats the state
  property p_commit_pass;
    state_reg == cpf_st_mem && $past(state_reg) != cpf_st_mem
      |-> $past(execute_pass) && $past(state_reg) == cpf_st_xfer;
  endproperty
  a_commit_pass: assert property (p_commit_pass)
    else $error("memory stage reached without execute pass");

  property p_cancel_drop;
    state_reg == cpf_st_mem && late_cancel && follower_clock_enable
      |=> $stable(commit_cnt_reg) && $stable(data_reg);
  endproperty
  a_cancel_drop: assert property (p_cancel_drop)
    else $error("state changed by a cancelled instruction");

  property p_abandon;
    (state_reg == cpf_st_wait || state_reg == cpf_st_xfer) && follower_clock_enable
      && !execute_pass |=> state_reg == cpf_st_idle ##1 $stable(commit_cnt_reg);
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("instruction not abandoned on pass low");

  c_busy_wait: cover property (state_reg == cpf_st_wait ##1 state_reg == cpf_st_xfer);
  c_commit:    cover property (state_reg == cpf_st_mem && !late_cancel && follower_clock_enable);
  c_cancel:    cover property (state_reg == cpf_st_mem && late_cancel && follower_clock_enable);
  c_burst:     cover property (execute_handshake == cpf_hs_go ##1 execute_handshake == cpf_hs_go);

endmodule : cpf_follower

`default_nettype wire

// >>> tb/cpf_core_model.sv
// Purpose: behavioural core that drives the follower port
// Assumes: one clock; follower outputs come from registers
// Notes:   commanded by the bench through task run
`default_nettype none

module cpf_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  output logic            follower_clock_enable,
  output logic [31:0]     follower_instruction_bus,
  output logic            instr_entry_n,
  output logic            execute_pass,
  output logic            late_cancel,
  output logic            compact_isa_flag,
  output logic            privilege_flag_n,
  output logic [31:0]     data_to_follower,
  input  wire logic [1:0] decode_handshake,
  input  wire logic [1:0] execute_handshake,
  input  wire logic [31:0] data_from_follower,
  input  wire logic [3:0] burst_word_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] rs;
  logic        watch, seen, cancel_req, claimed;
  logic [3:0]  burst_seen;
  logic [31:0] dout_seen;
  logic        seq[$];

  function automatic logic [31:0] rnd_next();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd_next

  initial begin
    rs = 32'd90914;
    follower_clock_enable = 1'b0;
    follower_instruction_bus = 32'h0;
    instr_entry_n = 1'b1;
    execute_pass = 1'b0;
    compact_isa_flag = 1'b0;
    privilege_flag_n = 1'b1;
    data_to_follower = 32'h0;
    {watch, seen, cancel_req, claimed, burst_seen} = '0;
  end

  // ----
  // monitor: one go or last per advancing edge, cancel in the cycle after the first go or last, the mem cycle for a single item
  // ----
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      late_cancel <= 1'b0;
    end else if (follower_clock_enable) begin
      if (watch && decode_handshake != 2'h2) claimed <= 1'b1;
      if (watch && execute_handshake[0] && !seen) begin
        if (seq.size() == 0) begin
          burst_seen <= burst_word_count;
          dout_seen  <= data_from_follower;
        end
        late_cancel <= cancel_req && seq.size() == 0;
        // each go or last execute cycle stands for one data-side access
        seq.push_back(execute_handshake[1]);
        seen <= execute_handshake[1];
      end else late_cancel <= 1'b0;
    end
  end

  task automatic run(input logic [31:0] ins, input logic pa, ca, pn, cm,
                     input logic [31:0] d);
    int k;
    @(posedge hclk);
    seq.delete();
    claimed <= 1'b0;
    seen <= 1'b0;
    watch <= 1'b1;
    cancel_req = ca;
    follower_clock_enable <= 1'b1;
    follower_instruction_bus <= ins;
    instr_entry_n <= 1'b0;
    execute_pass <= pa;
    privilege_flag_n <= pn;
    compact_isa_flag <= cm;
    data_to_follower <= d;
    for (k = 0; k < 48; k++) begin
      @(posedge hclk);
      follower_instruction_bus <= 32'h0;
      instr_entry_n <= (k == 0) || (k == 47);
      follower_clock_enable <= (k == 47) || (rnd_next() % 4 != 0);
    end
    execute_pass <= 1'b0;
    watch <= 1'b0;
  endtask : run
endmodule : cpf_core_model

`default_nettype wire

// >>> tb/tb_cpf_follower.sv
// Purpose: self-checking bench for the follower
// Assumes: the follower is set to claim coprocessor 5
// Notes:   expected count kept as a plain integer, expected data as a 32-bit vector
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t got %h want %h", $time, (a), (b)); end end

module tb_cpf_follower;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] k_cdp = 32'hee000500;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        en, entry_n, pass, cancel, compact, priv_n;
  logic [1:0]  htrans, dhs, ehs;
  logic [2:0]  hsize;
  logic [3:0]  burst;
  logic [31:0] haddr, hwdata, hrdata, ibus, d_to, d_from, exp_data, rd;
  int          err_total, num_checks, exp_count;

  cpf_follower i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .follower_clock_enable(en),
    .follower_instruction_bus(ibus), .instr_entry_n(entry_n), .execute_pass(pass),
    .late_cancel(cancel), .compact_isa_flag(compact), .privilege_flag_n(priv_n),
    .data_to_follower(d_to), .decode_handshake(dhs), .execute_handshake(ehs),
    .data_from_follower(d_from), .burst_word_count(burst));

  cpf_core_model i_core (.hclk(hclk), .hresetn(hresetn), .follower_clock_enable(en),
    .follower_instruction_bus(ibus), .instr_entry_n(entry_n), .execute_pass(pass),
    .late_cancel(cancel), .compact_isa_flag(compact), .privilege_flag_n(priv_n),
    .data_to_follower(d_to), .decode_handshake(dhs), .execute_handshake(ehs),
    .burst_word_count(burst), .data_from_follower(d_from));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    t = 0;
    do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
    rd = hrdata;
    `CHK(hresp, 1'b0)
    if (t >= 50) begin
      err_total++;
      conclude();
    end
  endtask : ahb

  task automatic op(input logic [31:0] cr, ins, input int pa, ca, pn, cm, cl, cmt, ngo);
    logic [31:0] d, dx;
    int i;
    d = i_core.rnd_next();
    ahb(1'b1, 8'h00, cr);
    i_core.run(ins, pa[0], ca[0], pn[0], cm[0], d);
    exp_count += (cmt != 0);
    if (cmt == 2) exp_data = d;
    dx = (ins[27:25] == 3'h6 && !ins[20]) ? exp_data : 32'h0;
    `CHK(i_core.claimed, cl[0])
    `CHK(i_core.seq.size(), ngo + 1)
    for (i = 0; i < i_core.seq.size(); i++) `CHK(i_core.seq[i], i == ngo)
    if (ins[27:25] == 3'h6 && ngo >= 0) `CHK(i_core.burst_seen, ngo[3:0])
    if (i_core.seq.size() > 0) `CHK(i_core.dout_seen, dx)
    `CHK(dhs, 2'h2)
    `CHK(burst, 4'h0)
    ahb(1'b0, 8'h0c, 32'h0);
    `CHK(rd[15:0], exp_count[15:0])
    ahb(1'b0, 8'h08, 32'h0);
    `CHK(rd, exp_data)
    $display("op %h done", ins);
  endtask : op

  initial begin
    {hresetn, hsel, htrans, haddr, hwrite, hwdata} = '0;
    hsize = 3'h2;
    {err_total, num_checks, exp_count} = '0;
    exp_data = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK({dhs, ehs}, 4'ha)
    `CHK({burst, d_from}, 36'h0)
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, 8'h04, 32'hffff_ffff);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h1)
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    $display("register test done");
    op(32'h51, k_cdp, 1, 0, 1, 0, 1, 1, 0);
    op(32'h51, k_cdp, 1, 1, 1, 0, 1, 0, 0);
    op(32'h51, 32'hee000600, 1, 0, 1, 0, 0, 0, -1);
    op(32'h51, k_cdp, 1, 0, 1, 1, 0, 0, -1);
    op(32'h51, k_cdp, 1, 0, 0, 0, 0, 0, -1);
    op(32'h53, k_cdp, 1, 0, 0, 0, 1, 1, 0);
    op(32'h51, 32'hee000510, 1, 0, 1, 0, 1, 2, 0);
    op(32'h3251, 32'hed900500, 1, 0, 1, 0, 1, 2, 3);
    op(32'h0251, k_cdp, 0, 0, 1, 0, 1, 0, -1);
    op(32'hf051, 32'hed800500, 1, 0, 1, 0, 1, 1, 15);
    op(32'h0, k_cdp, 1, 0, 1, 0, 0, 0, -1);
    conclude();
  end
endmodule : tb_cpf_follower

`default_nettype wire
